// ---- hw/rate_gen_defs.svh ----
// register offsets, field positions, reset values and timing figures
// of the serial rate clock generator; definitions only
`ifndef RATE_GEN_DEFS_SVH
`define RATE_GEN_DEFS_SVH

// register offsets on the plain register port
`define RG_ADDR_W 2
`define RG_OFF_PRESCALE_SELECT 2'h0
`define RG_OFF_RELOAD_VALUE 2'h1
`define RG_OFF_SERIAL_MODE 2'h2
`define RG_OFF_STATUS 2'h3

// prescale select fields
`define RG_PS_CODE_LSB 0
`define RG_PS_CODE_MSB 1
`define RG_PS_ENABLE_BIT 2

// serial mode control one fields
`define RG_SM_CLK_SEL_BIT 0

// reset values
`define RG_RESET_PRESCALE 8'h00
`define RG_RESET_RELOAD 8'h00
`define RG_RESET_MODE 8'h00

// serial port internal division
`define RG_SERIAL_DIV 4
`define RG_MIN_RELOAD 8'h02

`endif

// ---- hw/rate_gen_pkg.sv ----
// types shared by the serial rate clock generator files
// assumes the constants header is included by the design files
package rate_gen_pkg;

    typedef logic [7:0] byte_t;

    // prescale code encodings
    typedef enum logic [1:0] {
        PS_DIV1 = 2'h0,
        PS_DIV2 = 2'h1,
        PS_DIV4 = 2'h2,
        PS_DIV8 = 2'h3
    } prescale_code_t;

    // rate counter states, gray along idle -> load -> run
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOAD = 2'h1,
        ST_RUN = 2'h3
    } rate_state_t;

endpackage

// ---- hw/rate_prescaler.sv ----
// input prescaler: divides the selected source tick by 1, 2, 4 or 8
// assumes src_tick_in is a one-cycle pulse on clk_in
`timescale 1ns/1ns
`default_nettype none

module rate_prescaler
    import rate_gen_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    input wire prescale_code_t code_in,
    input wire logic src_tick_in,
    // output
    output logic tick_out
);

    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } pre_state_t;

    pre_state_t s_q;
    pre_state_t s_d;
    logic [2:0] limit;

    // divide ratio minus one from the code
    always_comb begin
        case (code_in)
            PS_DIV1: limit = 3'h0;
            PS_DIV2: limit = 3'h1;
            PS_DIV4: limit = 3'h3;
            PS_DIV8: limit = 3'h7;
            default: limit = 3'h0;
        endcase
    end

    // count source ticks; restarts whenever the generator is stopped
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run_in) begin
            s_d.cnt = 3'h0;
        end else if (src_tick_in) begin
            if (s_q.cnt >= limit) begin // (R6)
                s_d.cnt = 3'h0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;

endmodule

`default_nettype wire

// ---- hw/rate_quarter_div.sv ----
// serial port side divider: turns rate clock pulses into bit ticks
// one bit tick per four rate clock pulses, as the serial port does
`timescale 1ns/1ns
`default_nettype none
`include "rate_gen_defs.svh"

module rate_quarter_div
    import rate_gen_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // input pulses
    input wire logic run_in,
    input wire logic pulse_in,
    // bit tick
    output logic tick_out
);

    typedef struct packed {
        logic [1:0] cnt;
        logic tick;
    } quarter_state_t;

    quarter_state_t s_q;
    quarter_state_t s_d;

    // four pulses per bit tick
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run_in) begin
            s_d.cnt = 2'h0;
        end else if (pulse_in) begin
            s_d.cnt = s_q.cnt + 2'h1;
            s_d.tick = (s_q.cnt == 2'(`RG_SERIAL_DIV - 1)); // (R4)
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;

endmodule

`default_nettype wire

// ---- hw/rate_gen.sv ----
// How it works
// (R1) source clock is the shared prescaler tick or the machine clock
// (R2) divided rate clock goes to the serial channel as its shift source
// (R3) serial port uses the generator output when its clock select picks it
// (R4) serial port divides by four; total is prescale times reload times four
// (R5) exact integer division keeps the rate within three percent
// (R6) prescale code 00,01,10,11 divides by 1,2,4,8
// (R7) writing enable one loads the reload value and starts the rate clock
// (R8) writing enable zero halts the rate clock
// (R9) upper five prescale select bits read zero, writes ignored
// (R10) reload register sets the down-counter period
// (R11) software stops the serial port before changing the reload value
// (R12) software keeps the reload value within 0x02 to 0xff
// (R13) down-counter counts prescaled ticks, pulses on expiry and reloads
//
// top of the serial rate clock generator, one channel
// assumes a plain register port with read data one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
`include "rate_gen_defs.svh"

module rate_gen
    import rate_gen_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [`RG_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // source clock selection and shared prescaler tick
    input wire logic src_sel_in,
    input wire logic shared_tick_in,
    // serial port clocks
    input wire logic alt_clock_in,
    output logic rate_clock_out,
    output logic serial_clock_out,
    output logic bit_tick_out
);

    typedef struct packed {
        logic enable;
        logic [1:0] code;
        byte_t reload;
        logic clk_sel;
        byte_t count;
        rate_state_t state;
        logic rate_pulse;
        logic serial_clk;
        logic bit_tick;
        byte_t rdata;
    } gen_state_t;

    gen_state_t s_q;
    gen_state_t s_d;
    logic src_tick;
    logic pre_tick;
    logic quarter_tick;
    logic running;

    ////////////////////////////////////////////////////////////////////
    // source selection: machine clock ticks every cycle
    assign src_tick = src_sel_in ? shared_tick_in : 1'b1; // (R1)
    assign running = (s_q.state == ST_RUN);

    rate_prescaler u_prescaler (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(running),
        .code_in(prescale_code_t'(s_q.code)),
        .src_tick_in(src_tick),
        .tick_out(pre_tick)
    );

    rate_quarter_div u_quarter (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(running),
        .pulse_in(s_q.rate_pulse),
        .tick_out(quarter_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // register writes, counter and read mux in one next-state process
    always_comb begin
        s_d = s_q;
        s_d.rate_pulse = 1'b0;
        // register writes
        if (wr_in) begin
            case (addr_in)
                `RG_OFF_PRESCALE_SELECT: begin
                    s_d.enable = wdata_in[`RG_PS_ENABLE_BIT];
                    s_d.code = wdata_in[`RG_PS_CODE_MSB:`RG_PS_CODE_LSB]; // (R9)
                end
                `RG_OFF_RELOAD_VALUE: begin
                    s_d.reload = wdata_in; // (R10)
                end
                `RG_OFF_SERIAL_MODE: begin
                    s_d.clk_sel = wdata_in[`RG_SM_CLK_SEL_BIT];
                end
                default: begin
                end
            endcase
        end
        // counter sequencing
        case (s_q.state)
            ST_IDLE: begin
                if (s_q.enable) begin
                    s_d.state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                s_d.count = s_q.reload; // (R7)
                s_d.state = s_q.enable ? ST_RUN : ST_IDLE;
            end
            ST_RUN: begin
                if (!s_q.enable) begin
                    s_d.state = ST_IDLE; // (R8)
                end else if (pre_tick) begin
                    // reload values below two are not valid for the serial port
                    if (s_q.count <= 8'h01) begin
                        s_d.count = s_q.reload; // (R13)
                        s_d.rate_pulse = 1'b1; // (R10)
                    end else begin
                        s_d.count = s_q.count - 8'h01; // (R5)
                    end
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
        // every write of enable one restarts with a fresh load, even when running
        if (wr_in && addr_in == `RG_OFF_PRESCALE_SELECT && wdata_in[`RG_PS_ENABLE_BIT]) begin
            s_d.state = ST_LOAD; // (R7)
        end
        // serial clock: rate clock only when selected
        s_d.serial_clk = s_q.clk_sel ? s_q.rate_pulse : alt_clock_in; // (R3)
        s_d.bit_tick = s_q.clk_sel & quarter_tick; // (R4)
        // read data, valid the cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `RG_OFF_PRESCALE_SELECT:
                    s_d.rdata = {5'h00, s_q.enable, s_q.code}; // (R9)
                `RG_OFF_RELOAD_VALUE: s_d.rdata = s_q.reload;
                `RG_OFF_SERIAL_MODE: s_d.rdata = {7'h00, s_q.clk_sel};
                `RG_OFF_STATUS: s_d.rdata = s_q.count;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign rate_clock_out = s_q.rate_pulse; // (R2)
    assign serial_clock_out = s_q.serial_clk;
    assign bit_tick_out = s_q.bit_tick;
    assign rdata_out = s_q.rdata;

endmodule

`default_nettype wire

// ---- tb/rate_gen_chk.sv ----
// port checker for the rate clock generator
// assumes one clock domain, reset asynchronous and active high
`timescale 1ns/1ns
`default_nettype none
`include "rate_gen_defs.svh"
module rate_gen_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [`RG_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // clocks
    input wire logic src_sel_in,
    input wire logic shared_tick_in,
    input wire logic rate_clock_out,
    input wire logic bit_tick_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    // register read side
    property p_rd_idle; !rd_in |=> rdata_out == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_ps_rd; wr_in && addr_in == `RG_OFF_PRESCALE_SELECT ##1
        rd_in && addr_in == `RG_OFF_PRESCALE_SELECT
        |=> rdata_out == {5'h00, $past(wdata_in[2:0], 2)}; endproperty
    a_ps_rd: assert property (p_ps_rd) else $error("prescale readback wrong");
    property p_rl_rd; wr_in && addr_in == `RG_OFF_RELOAD_VALUE ##1
        rd_in && addr_in == `RG_OFF_RELOAD_VALUE |=> rdata_out == $past(wdata_in, 2);
    endproperty
    a_rl_rd: assert property (p_rl_rd) else $error("reload readback wrong");
    property p_upper; rd_in && addr_in == `RG_OFF_PRESCALE_SELECT
        |=> rdata_out[7:3] == 5'h00; endproperty
    a_upper: assert property (p_upper) else $error("upper prescale bits set");
    ////////////////////////////////////////////////////////////////////////
    // rate clock side; a pulse may already be in flight when halted
    property p_halt; wr_in && addr_in == `RG_OFF_PRESCALE_SELECT && !wdata_in[2]
        |-> ##2 !rate_clock_out [*8]; endproperty
    a_halt: assert property (p_halt) else $error("rate clock after halt");
    property p_rate_gap; rate_clock_out |=> !rate_clock_out; endproperty
    a_rate_gap: assert property (p_rate_gap) else $error("rate pulses adjacent");
    property p_bit_gap; bit_tick_out |=> !bit_tick_out [*3]; endproperty
    a_bit_gap: assert property (p_bit_gap) else $error("bit ticks too close");
    property p_stall; (src_sel_in && !shared_tick_in) [*6] |-> !rate_clock_out;
    endproperty
    a_stall: assert property (p_stall) else $error("pulse without source");
endmodule
bind rate_gen rate_gen_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .src_sel_in(src_sel_in), .shared_tick_in(shared_tick_in),
    .rate_clock_out(rate_clock_out), .bit_tick_out(bit_tick_out));
`default_nettype wire

// ---- tb/serial_port_model.sv ----
// far side: serial port counting shift clock pulses and bit ticks
// assumes one-cycle pulses on the machine clock
`timescale 1ns/1ns
`default_nettype none
module serial_port_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // clocks from the generator
    input wire logic serial_clock_in,
    input wire logic bit_tick_in,
    // counts
    output int pulses_out,
    output int bits_out,
    output int gap_out
);
    int cnt_q;
    // gap is cycles between shift clock pulses, taken as shift source
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 0;
            pulses_out <= 0;
            bits_out <= 0;
            gap_out <= 0;
        end else begin
            cnt_q <= serial_clock_in ? 0 : cnt_q + 1;
            if (serial_clock_in) begin
                gap_out <= cnt_q + 1;
                pulses_out <= pulses_out + 1;
            end
            if (bit_tick_in) begin
                bits_out <= bits_out + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/rate_gen_tb_top.sv ----
// bench for the rate clock generator with a serial port model
// assumes the design and checker files are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "rate_gen_defs.svh"
module rate_gen_tb_top;
    import rate_gen_pkg::*;
    typedef struct {logic src; prescale_code_t code; byte_t rl; int gap;} row_t;
    logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, src_sel_in = 0;
    logic shared_tick_in = 0, alt_clock_in = 0;
    logic [`RG_ADDR_W-1:0] addr_in = '0;
    byte_t wdata_in = 8'h00;
    logic [7:0] rdata_out;
    logic rate_clock_out, serial_clock_out, bit_tick_out;
    int pulses, bits, gap, p0, b0, miscompares = 0, n_checks = 0;
    row_t rows[6] = '{'{0, PS_DIV1, 8'h02, 2}, '{0, PS_DIV2, 8'h03, 6},
        '{0, PS_DIV4, 8'h03, 12}, '{0, PS_DIV8, 8'h03, 24},
        '{0, PS_DIV1, 8'hff, 255}, '{1, PS_DIV1, 8'h02, 4}};
    rate_gen u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .src_sel_in(src_sel_in), .shared_tick_in(shared_tick_in),
        .alt_clock_in(alt_clock_in), .rate_clock_out(rate_clock_out),
        .serial_clock_out(serial_clock_out), .bit_tick_out(bit_tick_out));
    serial_port_model u_port (.clk_in(clk_in), .rst_in(rst_in),
        .serial_clock_in(serial_clock_out), .bit_tick_in(bit_tick_out),
        .pulses_out(pulses), .bits_out(bits), .gap_out(gap));
    ////////////////////////////////////////////////////////////////////////
    // 50 ns clock; shared prescaler ticks every second cycle
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) shared_tick_in <= ~shared_tick_in;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // an edge passes after each strobe so strobes never collide
    task automatic wr(input logic [`RG_ADDR_W-1:0] a, input byte_t d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1;
        @(posedge clk_in);
        wr_in <= 0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [`RG_ADDR_W-1:0] a, input byte_t e);
        addr_in <= a;
        rd_in <= 1;
        @(posedge clk_in);
        rd_in <= 0;
        #1 chk("rdata", rdata_out, e);
        @(posedge clk_in);
    endtask
    // write then read at once, strobes back to back
    task automatic wr_rd(input logic [`RG_ADDR_W-1:0] a, input byte_t d, input byte_t e);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1;
        @(posedge clk_in);
        wr_in <= 0;
        rd_in <= 1;
        @(posedge clk_in);
        rd_in <= 0;
        #1 chk("wr_rd", rdata_out, e);
        @(posedge clk_in);
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the longest row
    initial begin
        #3000000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        wr(`RG_OFF_SERIAL_MODE, 8'h01);
        foreach (rows[i]) begin
            src_sel_in <= rows[i].src;
            wr(`RG_OFF_PRESCALE_SELECT, 8'h00);
            repeat (10) @(posedge clk_in);
            wr(`RG_OFF_RELOAD_VALUE, rows[i].rl);
            wr(`RG_OFF_PRESCALE_SELECT, {5'h00, 1'b1, rows[i].code});
            p0 = pulses;
            b0 = bits;
            for (int k = 0; k < 3000 && pulses < p0 + 9; k++) @(posedge clk_in);
            chk("gap", gap, rows[i].gap);
            chk("bits", bits - b0, 2);
        end
        // halting stops the shift clock for good
        wr(`RG_OFF_PRESCALE_SELECT, 8'h00);
        repeat (3) @(posedge clk_in);
        p0 = pulses;
        repeat (40) @(posedge clk_in);
        chk("halted", pulses, p0);
        wr(`RG_OFF_PRESCALE_SELECT, 8'hf9);
        rd(`RG_OFF_PRESCALE_SELECT, 8'h01);
        rd(`RG_OFF_RELOAD_VALUE, 8'h02);
        wr_rd(`RG_OFF_PRESCALE_SELECT, 8'hfb, 8'h03);
        wr_rd(`RG_OFF_RELOAD_VALUE, 8'h5a, 8'h5a);
        // second reset with the generator halted clears every register
        rst_in <= 1;
        repeat (2) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        rd(`RG_OFF_PRESCALE_SELECT, 8'h00);
        rd(`RG_OFF_RELOAD_VALUE, 8'h00);
        rd(`RG_OFF_SERIAL_MODE, 8'h00);
        // clock select now zero: the other serial clock passes through
        alt_clock_in <= 1;
        @(posedge clk_in);
        alt_clock_in <= 0;
        repeat (2) @(posedge clk_in);
        chk("alt_clock", pulses, 1);
        end_of_test();
    end
endmodule
`default_nettype wire
